// File: hw/srs_port.sv
// Host port of the sensor: I2C and SPI slave, result shadows, status and gas control
`include "srs_defs.svh"

module srs_port (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              sck,
  input  wire logic              chip_select_n,
  input  wire logic              serial_data_pin_i,
  output logic                   serial_data_pin_o,
  output logic                   serial_data_pin_oe,
  input  wire logic              address_select_pin_i,
  output logic                   address_select_pin_o,
  output logic                   address_select_pin_oe,
  input  wire srs_pkg::srs_meas_s meas_i,
  output srs_pkg::srs_ctl_s      ctl_o,
  output logic                   spi_locked_o
);
  import srs_pkg::*;

  // ****************************************
  // Register read decode
  // ****************************************
  function automatic logic [7:0] rd_fn(input logic [7:0] a, input srs_res_s r,
                                       input srs_ctl_s c, input logic w3);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `SRS_A_STATUS: v = {r.new_data, r.gas_meas, r.meas, 1'b0, r.idx};
      `SRS_A_PMSB:   v = r.press[19:12];
      `SRS_A_PLSB:   v = r.press[11:4];
      `SRS_A_PXLSB:  v = {r.press[3:0], 4'h0};
      `SRS_A_TMSB:   v = r.temp[19:12];
      `SRS_A_TLSB:   v = r.temp[11:4];
      `SRS_A_TXLSB:  v = {r.temp[3:0], 4'h0};
      `SRS_A_HMSB:   v = r.hum[15:8];
      `SRS_A_HLSB:   v = r.hum[7:0];
      `SRS_A_GMSB:   v = r.gas[9:2];
      `SRS_A_GLSB:   v = {r.gas[1:0], r.gas_valid, r.heat_stab, r.range};
      `SRS_A_CTRL:   v = {3'h0, c.run_gas, c.setpoint};
      `SRS_A_CFG:    v = {7'h00, w3};
      default:       v = 8'h00;
    endcase
    return v;
  endfunction

  // ****************************************
  // Reset release and pin synchronisers
  // ****************************************
  logic [1:0] rst_q;
  logic       rst_n;
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [2:0] s3_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // Bits: 3 address select, 2 chip select, 1 data, 0 serial clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 4'hF;
      s2_q <= 4'hF;
      s3_q <= 3'h7;
    end else begin
      s1_q <= {address_select_pin_i, chip_select_n, serial_data_pin_i, sck};
      s2_q <= s1_q;
      s3_q <= s2_q[2:0];
    end
  end

  // ****************************************
  // SPI engine on the serial clock
  // ****************************************
  logic [2:0] bc_q, bc_d;
  logic [7:0] sh_q, sh_d;
  logic [6:0] sa_q, sa_d;
  logic       cd_q, cd_d;
  logic       srw_q, srw_d;
  logic       wt_q, wt_d;
  logic [6:0] wa_q, wa_d;
  logic [7:0] wd_q, wd_d;
  logic [7:0] tx_q, tx_d;
  logic       sdo_q, sdo_d;
  logic       oe3_q, oe3_d;
  logic       oe4_q, oe4_d;
  logic       spi3w_q, spi3w_d;
  srs_res_s   snap_q, snap_d;
  srs_ctl_s   ctl_q, ctl_d;
  logic [7:0] sbyte;

  always_comb begin
    sh_d  = {sh_q[6:0], serial_data_pin_i};
    bc_d  = bc_q + 3'h1;
    sa_d  = sa_q;
    cd_d  = cd_q;
    srw_d = srw_q;
    wt_d  = wt_q;
    wa_d  = wa_q;
    wd_d  = wd_q;
    if (bc_q == `SRS_BIT_LAST) begin
      if (!cd_q) begin
        sa_d  = sh_d[6:0];
        srw_d = sh_d[7];
        cd_d  = 1'b1;
      end else if (!srw_q) begin
        wt_d = ~wt_q;
        wa_d = sa_q;
        wd_d = sh_d;
        cd_d = 1'b0;
      end else begin
        sa_d = sa_q + 7'h01;
      end
    end
  end

  // Frame state ends with the frame's own chip select
  always_ff @(posedge sck or posedge chip_select_n) begin
    if (chip_select_n) begin
      bc_q  <= 3'h0;
      sh_q  <= 8'h00;
      sa_q  <= 7'h00;
      cd_q  <= 1'b0;
      srw_q <= 1'b0;
    end else begin
      bc_q  <= bc_d;
      sh_q  <= sh_d;
      sa_q  <= sa_d;
      cd_q  <= cd_d;
      srw_q <= srw_d;
    end
  end

  always_ff @(posedge sck or negedge rstn) begin
    if (!rstn) begin
      wt_q <= 1'b0;
      wa_q <= 7'h00;
      wd_q <= 8'h00;
    end else begin
      wt_q <= wt_d;
      wa_q <= wa_d;
      wd_q <= wd_d;
    end
  end

  // Output changes on falling edge: serves modes 00 and 11
  always_comb begin
    sbyte = rd_fn({1'b0, sa_q}, snap_q, ctl_q, spi3w_q);
    tx_d  = tx_q;
    sdo_d = sdo_q;
    oe3_d = oe3_q;
    oe4_d = oe4_q;
    if (cd_q && srw_q) begin
      if (bc_q == 3'h0) begin
        sdo_d = sbyte[7];
        tx_d  = {sbyte[6:0], 1'b0};
      end else begin
        sdo_d = tx_q[7];
        tx_d  = {tx_q[6:0], 1'b0};
      end
      oe3_d = spi3w_q;
      oe4_d = ~spi3w_q;
    end
  end

  always_ff @(negedge sck or posedge chip_select_n) begin
    if (chip_select_n) begin
      tx_q  <= 8'h00;
      sdo_q <= 1'b0;
      oe3_q <= 1'b0;
      oe4_q <= 1'b0;
    end else begin
      tx_q  <= tx_d;
      sdo_q <= sdo_d;
      oe3_q <= oe3_d;
      oe4_q <= oe4_d;
    end
  end

  // ****************************************
  // Interface lock, write crossing, registers
  // ****************************************
  logic       lock_q, lock_d;
  logic [2:0] ws_q;
  logic       spi_start;
  logic       swev;
  logic       i_wen;
  logic       i_cap;
  logic [7:0] ptr_q, ptr_d;
  logic [7:0] ish_q, ish_d;
  srs_res_s   res_q, res_d;

  assign spi_start = s3_q[2] & ~s2_q[2];
  assign swev      = ws_q[2] ^ ws_q[1];

  always_comb begin
    lock_d  = lock_q | ~s2_q[2];
    snap_d  = (spi_start || i_cap) ? res_q : snap_q;
    ctl_d   = ctl_q;
    spi3w_d = spi3w_q;
    if (swev || i_wen) begin
      case (swev ? {1'b0, wa_q} : ptr_q)
        `SRS_A_CTRL: begin
          ctl_d.run_gas = swev ? wd_q[`SRS_B_RUN] : ish_q[`SRS_B_RUN];
          if ((swev ? wd_q[3:0] : ish_q[3:0]) <= `SRS_SP_MAX) begin
            ctl_d.setpoint = swev ? wd_q[3:0] : ish_q[3:0];
          end
        end
        `SRS_A_CFG: spi3w_d = swev ? wd_q[`SRS_B_SPI3W] : ish_q[`SRS_B_SPI3W];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_q  <= 1'b0;
      ws_q    <= 3'h0;
      snap_q  <= '0;
      ctl_q   <= '0;
      spi3w_q <= 1'b0;
    end else begin
      lock_q  <= lock_d;
      ws_q    <= {ws_q[1:0], wt_q};
      snap_q  <= snap_d;
      ctl_q   <= ctl_d;
      spi3w_q <= spi3w_d;
    end
  end

  // ****************************************
  // Result and status capture
  // ****************************************
  always_comb begin
    res_d = res_q;
    if (meas_i.busy) begin
      res_d.meas = 1'b1;
      res_d.new_data = 1'b0;
    end
    if (meas_i.gas_busy) begin
      res_d.gas_meas = 1'b1;
    end
    if (meas_i.done) begin
      res_d.new_data  = 1'b1;
      res_d.meas      = meas_i.busy;
      res_d.gas_meas  = meas_i.gas_busy;
      res_d.idx       = meas_i.idx;
      res_d.press     = meas_i.skip_p ? `SRS_SKIP20 : meas_i.press;
      res_d.temp      = meas_i.skip_t ? `SRS_SKIP20 : meas_i.temp;
      res_d.hum       = meas_i.skip_h ? `SRS_SKIP16 : meas_i.hum;
      res_d.gas       = meas_i.gas;
      res_d.gas_valid = meas_i.gas_valid;
      res_d.heat_stab = meas_i.heat_stab;
      res_d.range     = meas_i.range;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res_q <= '{press: `SRS_SKIP20, temp: `SRS_SKIP20, hum: `SRS_SKIP16, default: '0};
    end else begin
      res_q <= res_d;
    end
  end

  // ****************************************
  // I2C engine, oversampled
  // ****************************************
  srs_i2c_e   st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic       irw_q, irw_d;
  logic       ph_q, ph_d;
  logic       nack_q, nack_d;
  logic       ioe_q, ioe_d;
  logic       rise, fall, start, stop;
  logic [7:0] ib;

  assign rise  = s2_q[0] & ~s3_q[0];
  assign fall  = ~s2_q[0] & s3_q[0];
  assign start = s2_q[0] & s3_q[0] & s3_q[1] & ~s2_q[1];
  assign stop  = s2_q[0] & s3_q[0] & ~s3_q[1] & s2_q[1];

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    ish_d  = ish_q;
    ptr_d  = ptr_q;
    irw_d  = irw_q;
    ph_d   = ph_q;
    nack_d = nack_q;
    ioe_d  = ioe_q;
    i_wen  = 1'b0;
    i_cap  = 1'b0;
    ib     = rd_fn(ptr_q, (st_q == SRS_I_AACK) ? res_q : snap_q, ctl_q, spi3w_q);
    if (lock_q || stop) begin
      st_d  = SRS_I_IDLE;
      ioe_d = 1'b0;
    end else if (start) begin
      st_d  = SRS_I_ADDR;
      cnt_d = 4'h0;
      ioe_d = 1'b0;
    end else if (rise) begin
      cnt_d  = cnt_q + 4'h1;
      nack_d = s2_q[1];
      if (st_q != SRS_I_RD) begin
        ish_d = {ish_q[6:0], s2_q[1]};
      end
    end else if (fall) begin
      unique case (st_q)
        SRS_I_IDLE: ;
        SRS_I_ADDR: if (cnt_q == `SRS_ACK_CNT) begin
          cnt_d = 4'h0;
          irw_d = ish_q[0];
          if (ish_q[7:1] == {`SRS_I2C_HI, s2_q[3]}) begin
            st_d  = SRS_I_AACK;
            ioe_d = 1'b1;
          end else begin
            st_d = SRS_I_IDLE;
          end
        end
        SRS_I_AACK: begin
          cnt_d = 4'h0;
          ph_d  = 1'b0;
          if (irw_q) begin
            st_d  = SRS_I_RD;
            i_cap = 1'b1;
            ioe_d = ~ib[7];
            ish_d = {ib[6:0], 1'b0};
          end else begin
            st_d  = SRS_I_RX;
            ioe_d = 1'b0;
          end
        end
        SRS_I_RX: if (cnt_q == `SRS_ACK_CNT) begin
          cnt_d = 4'h0;
          st_d  = SRS_I_RACK;
          ioe_d = 1'b1;
          if (ph_q) begin
            i_wen = 1'b1;
          end else begin
            ptr_d = ish_q;
          end
        end
        SRS_I_RACK: begin
          cnt_d = 4'h0;
          st_d  = SRS_I_RX;
          ioe_d = 1'b0;
          ph_d  = ~ph_q;
        end
        SRS_I_RD: if (cnt_q == `SRS_ACK_CNT) begin
          st_d  = SRS_I_MACK;
          ioe_d = 1'b0;
          ptr_d = ptr_q + 8'h01;
        end else begin
          ioe_d = ~ish_q[7];
          ish_d = {ish_q[6:0], 1'b0};
        end
        SRS_I_MACK: if (nack_q) begin
          st_d = SRS_I_IDLE;
        end else begin
          st_d  = SRS_I_RD;
          cnt_d = 4'h0;
          ioe_d = ~ib[7];
          ish_d = {ib[6:0], 1'b0};
        end
        default: st_d = SRS_I_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q   <= SRS_I_IDLE;
      cnt_q  <= 4'h0;
      ish_q  <= 8'h00;
      ptr_q  <= 8'h00;
      irw_q  <= 1'b0;
      ph_q   <= 1'b0;
      nack_q <= 1'b0;
      ioe_q  <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      ish_q  <= ish_d;
      ptr_q  <= ptr_d;
      irw_q  <= irw_d;
      ph_q   <= ph_d;
      nack_q <= nack_d;
      ioe_q  <= ioe_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign serial_data_pin_o     = sdo_q;
  assign serial_data_pin_oe    = ioe_q | oe3_q;
  assign address_select_pin_o  = sdo_q;
  assign address_select_pin_oe = oe4_q;
  assign ctl_o                 = ctl_q;
  assign spi_locked_o          = lock_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_cs_low;
    !s2_q[2] ##1 !s2_q[2];
  endsequence
  sequence s_done_skip_p;
    meas_i.done && meas_i.skip_p;
  endsequence

  property p_lock_set;
    s_cs_low |-> lock_q ##1 lock_q;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("chip select low did not lock SPI");

  property p_lock_i2c;
    lock_q |=> (st_q == SRS_I_IDLE) && !ioe_q;
  endproperty
  a_lock_i2c: assert property (p_lock_i2c) else $error("I2C active after SPI lock");

  property p_skip_p;
    s_done_skip_p |=> res_q.press == `SRS_SKIP20;
  endproperty
  a_skip_p: assert property (p_skip_p) else $error("skipped pressure not forced");

  property p_skip_h;
    meas_i.done && meas_i.skip_h |=> res_q.hum == `SRS_SKIP16;
  endproperty
  a_skip_h: assert property (p_skip_h) else $error("skipped humidity not forced");

  property p_new_data;
    meas_i.done |=> res_q.new_data && res_q.idx == $past(meas_i.idx);
  endproperty
  a_new_data: assert property (p_new_data) else $error("new data or index missing");

  property p_gas_flag;
    meas_i.done && !meas_i.gas_busy |=> !res_q.gas_meas;
  endproperty
  a_gas_flag: assert property (p_gas_flag) else $error("gas measuring flag stuck");

  property p_meas_flag;
    meas_i.busy |=> res_q.meas;
  endproperty
  a_meas_flag: assert property (p_meas_flag) else $error("measuring flag not set");

  property p_snap_hold;
    s_cs_low ##0 !spi_start |=> $stable(snap_q);
  endproperty
  a_snap_hold: assert property (p_snap_hold) else $error("snapshot changed in frame");

  property p_setpoint;
    ctl_q.setpoint <= `SRS_SP_MAX;
  endproperty
  a_setpoint: assert property (p_setpoint) else $error("set-point index above nine");

  property p_addr_ack;
    st_q == SRS_I_ADDR && fall && cnt_q == `SRS_ACK_CNT && !lock_q && !stop && !start
      && ish_q[7:1] != {`SRS_I2C_HI, s2_q[3]} |=> !ioe_q;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("acked foreign address");
endmodule

// File: shared/srs_defs.svh
// Register map, field positions and fixed values of the sensor result port
`ifndef SRS_DEFS_SVH
`define SRS_DEFS_SVH
`define SRS_A_STATUS 8'h1D
`define SRS_A_PMSB   8'h1F
`define SRS_A_PLSB   8'h20
`define SRS_A_PXLSB  8'h21
`define SRS_A_TMSB   8'h22
`define SRS_A_TLSB   8'h23
`define SRS_A_TXLSB  8'h24
`define SRS_A_HMSB   8'h25
`define SRS_A_HLSB   8'h26
`define SRS_A_GMSB   8'h2A
`define SRS_A_GLSB   8'h2B
`define SRS_A_CTRL   8'h71
`define SRS_A_CFG    8'h75
`define SRS_B_RUN    4
`define SRS_B_SPI3W  0
`define SRS_SP_MAX   4'h9
`define SRS_SKIP20   20'h80000
`define SRS_SKIP16   16'h8000
`define SRS_I2C_HI   6'h3B
`define SRS_BIT_LAST 3'h7
`define SRS_ACK_CNT  4'h8
`endif

// File: shared/srs_pkg.sv
// Types shared by the sensor result port
package srs_pkg;
  typedef struct packed {
    logic        busy;
    logic        gas_busy;
    logic        done;
    logic        skip_t;
    logic        skip_p;
    logic        skip_h;
    logic        gas_valid;
    logic        heat_stab;
    logic [3:0]  idx;
    logic [3:0]  range;
    logic [19:0] press;
    logic [19:0] temp;
    logic [15:0] hum;
    logic [9:0]  gas;
  } srs_meas_s;

  typedef struct packed {
    logic        new_data;
    logic        gas_meas;
    logic        meas;
    logic [3:0]  idx;
    logic [19:0] press;
    logic [19:0] temp;
    logic [15:0] hum;
    logic [9:0]  gas;
    logic        gas_valid;
    logic        heat_stab;
    logic [3:0]  range;
  } srs_res_s;

  typedef struct packed {
    logic       run_gas;
    logic [3:0] setpoint;
  } srs_ctl_s;

  typedef enum logic [6:0] {
    SRS_I_IDLE = 7'h01,
    SRS_I_ADDR = 7'h02,
    SRS_I_AACK = 7'h04,
    SRS_I_RX   = 7'h08,
    SRS_I_RACK = 7'h10,
    SRS_I_RD   = 7'h20,
    SRS_I_MACK = 7'h40
  } srs_i2c_e;
endpackage

// File: test/srs_host.sv
// Host model: bit-banged I2C and SPI master on the sensor pins
module srs_host (
  output logic      sck,
  output logic      cs_n,
  output logic      address_select_pin,
  input  wire logic sda_w,
  input  wire logic miso_w
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] tx [16];
  logic [7:0] rx [16];

  initial begin
    sck  = 1'b1;
    cs_n = 1'b1;
    address_select_pin  = 1'b1;
  end

  // ****************************************
  // I2C bit level, slow enough for oversampling
  // ****************************************
  task automatic i2c_bit(input logic b, output logic r);
    #20 address_select_pin = b;
    #60 sck = 1'b1;
    #40 r = sda_w;
    #40 sck = 1'b0;
  endtask

  task automatic i2c_start();
    address_select_pin = 1'b1;
    #20 sck = 1'b1;
    #80 address_select_pin = 1'b0;
    #80 sck = 1'b0;
  endtask

  task automatic i2c_stop();
    #20 address_select_pin = 1'b0;
    #60 sck = 1'b1;
    #80 address_select_pin = 1'b1;
    #80;
  endtask

  task automatic i2c_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) i2c_bit(d[i], r);
    i2c_bit(1'b1, r);
    ack = ~r;
  endtask

  // Read one byte with the line released, then ack (0) or nack (1)
  task automatic i2c_rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      i2c_bit(1'b1, r);
      d[i] = r;
    end
    i2c_bit(last, r);
  endtask

  // ****************************************
  // SPI frame; clock stands at cpol outside it
  // ****************************************
  task automatic spi(input logic cpol, input int n, input logic rdm);
    logic [7:0] b;
    sck = cpol;
    #50 cs_n = 1'b0;
    #64;
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        sck = 1'b0;
        address_select_pin = (rdm && k > 0) ? ~address_select_pin : tx[k][i];
        #16 sck = 1'b1;
        b[i] = miso_w;
        #16;
      end
      rx[k] = b;
    end
    sck = cpol;
    #40 cs_n = 1'b1;
    #64;
  endtask
endmodule

// File: test/tb.sv
// Testbench of the sensor host port: I2C, SPI, results and status
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); num_errors++; end end
module tb;
  import srs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic      clk, rstn, sck, cs_n, hsdo, strap, sd_o, sd_oe, ad_o, ad_oe, lock;
  logic      w3, cp, nd, ms, gm;
  srs_meas_s meas, m, nm;
  srs_ctl_s  ctl, c;
  int        num_errors, n_compared, cyc;
  wire       sda_w = sd_oe ? sd_o : hsdo;
  wire       ad_w  = ad_oe ? ad_o : strap;

  srs_port dut (.clk(clk), .rstn(rstn), .sck(sck), .chip_select_n(cs_n),
    .serial_data_pin_i(sda_w), .serial_data_pin_o(sd_o), .serial_data_pin_oe(sd_oe),
    .address_select_pin_i(ad_w), .address_select_pin_o(ad_o),
    .address_select_pin_oe(ad_oe), .meas_i(meas), .ctl_o(ctl), .spi_locked_o(lock));
  srs_host host (.sck(sck), .cs_n(cs_n), .address_select_pin(hsdo), .sda_w(sda_w),
    .miso_w(w3 ? sda_w : ad_w));

  initial clk = 1'b0;
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  function automatic logic [7:0] exp_b(input logic [7:0] a);
    logic [19:0] p, t;
    logic [15:0] h;
    p = m.skip_p ? 20'h80000 : m.press;
    t = m.skip_t ? 20'h80000 : m.temp;
    h = m.skip_h ? 16'h8000 : m.hum;
    case (a)
      8'h1D: exp_b = {nd, gm, ms, 1'b0, m.idx};
      8'h1F: exp_b = p[19:12];
      8'h20: exp_b = p[11:4];
      8'h21: exp_b = {p[3:0], 4'h0};
      8'h22: exp_b = t[19:12];
      8'h23: exp_b = t[11:4];
      8'h24: exp_b = {t[3:0], 4'h0};
      8'h25: exp_b = h[15:8];
      8'h26: exp_b = h[7:0];
      8'h2A: exp_b = m.gas[9:2];
      8'h2B: exp_b = {m.gas[1:0], m.gas_valid, m.heat_stab, m.range};
      8'h71: exp_b = {3'h0, c};
      8'h75: exp_b = {7'h00, w3};
      default: exp_b = 8'h00;
    endcase
  endfunction

  function automatic srs_meas_s gen();
    srs_meas_s v;
    v = srs_meas_s'(82'({$urandom, $urandom, $urandom}));
    v.busy = 1'b0;
    v.gas_busy = 1'b0;
    v.done = 1'b1;
    v.idx = 4'($urandom_range(9));
    v.skip_t = ($urandom_range(3) == 0);
    v.skip_p = ($urandom_range(3) == 0);
    v.skip_h = ($urandom_range(3) == 0);
    return v;
  endfunction

  task automatic pulse(input srs_meas_s v);
    @(negedge clk);
    meas = v;
    @(negedge clk);
    meas.done = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input int n);
    host.tx[0] = {1'b1, a[6:0]};
    cp = ~cp;
    host.spi(cp, n + 1, 1'b1);
    for (int i = 0; i < n; i++) `CHK("read byte", exp_b(a + 8'(i)), host.rx[i + 1])
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.tx[0] = {1'b0, a[6:0]};
    host.tx[1] = d;
    cp = ~cp;
    host.spi(cp, 2, 1'b0);
  endtask

  task automatic i2c_wr(input logic [6:0] sa, input logic [7:0] d, input logic ok);
    logic a;
    host.i2c_start();
    host.i2c_byte({sa, 1'b0}, a);
    `CHK("i2c address ack", ok, a)
    if (ok) begin
      host.i2c_byte(8'h71, a);
      `CHK("i2c register ack", 1'b1, a)
      host.i2c_byte(d, a);
      `CHK("i2c data ack", 1'b1, a)
    end
    host.i2c_stop();
  endtask

  // Pointer write, stop, then burst read at address 0x77
  task automatic i2c_rd(input logic [7:0] ra, input int n);
    logic       a;
    logic [7:0] d;
    host.i2c_start();
    host.i2c_byte({7'h77, 1'b0}, a);
    host.i2c_byte(ra, a);
    host.i2c_stop();
    host.i2c_start();
    host.i2c_byte({7'h77, 1'b1}, a);
    `CHK("i2c read ack", 1'b1, a)
    for (int i = 0; i < n; i++) begin
      host.i2c_rbyte(i == n - 1, d);
      `CHK("i2c read byte", exp_b(ra + 8'(i)), d)
    end
    host.i2c_stop();
  endtask

  initial begin
    void'($urandom(24));
    rstn = 1'b0;
    meas = '0;
    strap = 1'b0;
    {w3, cp, nd, ms, gm} = '0;
    m = '0;
    {m.skip_t, m.skip_p, m.skip_h} = 3'b111;
    c = '0;
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    repeat (10) @(negedge clk);
    `CHK("ctl reset", c, ctl)
    `CHK("lock reset", 1'b0, lock)
    // I2C address from strap, control writes
    i2c_wr(7'h77, 8'h13, 1'b0);
    i2c_wr(7'h76, 8'h13, 1'b1);
    c = '{1'b1, 4'h3};
    `CHK("ctl i2c", c, ctl)
    @(negedge clk);
    strap = 1'b1;
    i2c_wr(7'h76, 8'h07, 1'b0);
    i2c_wr(7'h77, 8'h07, 1'b1);
    c = '{1'b0, 4'h7};
    `CHK("ctl i2c", c, ctl)
    nm = gen();
    fork
      i2c_rd(8'h1D, 15);
      begin
        #8000;
        pulse(nm);
      end
    join
    m = nm;
    nd = 1'b1;
    $display("test i2c done");
    // First chip select low locks SPI
    rd(8'h1D, 15);
    `CHK("spi lock", 1'b1, lock)
    i2c_wr(7'h77, 8'h05, 1'b0);
    $display("test lock done");
    for (int i = 0; i < 12; i++) begin
      wr(8'h71, {3'h0, (i > 9) ? c.run_gas : 1'(i), 4'(i)});
      if (i <= 9) c = '{1'(i), 4'(i)};
      `CHK("ctl spi", c, ctl)
      rd(8'h71, 1);
    end
    wr(8'h1F, 8'hA5);
    rd(8'h1F, 1);
    $display("test control done");
    for (int i = 0; i < 8; i++) begin
      nm = gen();
      if (i < 2) nm.idx = i ? 4'h0 : 4'h9;
      pulse(nm);
      m = nm;
      nd = 1'b1;
      rd(8'h1D, 15);
      if (i == 3) begin
        host.tx[0] = 8'h71;
        host.tx[1] = 8'h12;
        host.tx[2] = 8'h75;
        host.tx[3] = 8'h01;
        host.spi(cp, 4, 1'b0);
        c = '{1'b1, 4'h2};
        w3 = 1'b1;
        rd(8'h71, 5);
      end
    end
    $display("test results done");
    @(negedge clk);
    meas.busy = 1'b1;
    meas.gas_busy = 1'b1;
    {nd, ms, gm} = 3'b011;
    rd(8'h1D, 1);
    @(negedge clk);
    meas.gas_busy = 1'b0;
    rd(8'h1D, 1);
    nm = gen();
    pulse(nm);
    m = nm;
    {nd, ms, gm} = 3'b100;
    rd(8'h1D, 1);
    $display("test flags done");
    nm = gen();
    fork
      rd(8'h1D, 15);
      begin
        #1000;
        pulse(nm);
      end
    join
    m = nm;
    rd(8'h1D, 15);
    $display("test snapshot done");
    summarize();
  end
endmodule
